// [ext_bus_timing_pkg.sv]
package ext_bus_timing_pkg;

   // ****************************************
   // widths and encodings
   // ****************************************
   localparam int SPACE_COUNT = 4;
   localparam int HALF_W = 7;
   localparam int CYC_W = 6;
   localparam int REF_W = 12;
   localparam logic FORMAT_SEPARATE = 1'b0;
   localparam logic FORMAT_MULTIPLEXED = 1'b1;

   // pbus_divide: 00 /1, 01 /2, 10 /3, 11 /4 of the base clock
   localparam logic [1:0] PBUS_DIV1 = 2'h0;
   localparam logic [1:0] PBUS_DIV2 = 2'h1;
   localparam logic [1:0] PBUS_DIV3 = 2'h2;
   localparam logic [1:0] PBUS_DIV4 = 2'h3;

   // ****************************************
   // half-cycle offsets of the four phases
   // ****************************************
   localparam logic [HALF_W-1:0] SEP_READ_SETUP_ADD = 7'h01;
   localparam logic [HALF_W-1:0] MUX_READ_SETUP_ADD = 7'h02;
   localparam logic [HALF_W-1:0] SEP_READ_WIDTH_ADD = 7'h01;
   localparam logic [HALF_W-1:0] MUX_READ_WIDTH_SUB = 7'h01;
   localparam logic [HALF_W-1:0] WRITE_SETUP_ADD = 7'h02;
   localparam logic [HALF_W-1:0] WRITE_WIDTH_SUB = 7'h01;

   // ****************************************
   // carriers
   // ****************************************
   typedef struct packed {
      logic bus_format_select;
      logic [1:0] timing_multiplier;
      logic [1:0] read_setup_count;
      logic [1:0] read_width_count;
      logic [1:0] write_setup_count;
      logic [1:0] write_width_count;
   } space_timing_type;

   typedef struct packed {
      logic write;
      logic internal;
      logic [1:0] space;
   } access_type;

   localparam space_timing_type TIMING_RESET = '0;
   localparam access_type ACCESS_RESET = '0;

   typedef enum logic [1:0] {IDLE, SETUP, PULSE, PAD} phase_type;

endpackage

// [ext_bus_timing.sv]
`timescale 1ns/100ps
// Contract
// - timing from per-space configs, base-clock units
// - multiplier field 00b..11b gives 1..4
// - read setup sur*mpy plus 0.5 or 1
// - read width wr*mpy plus/minus 0.5
// - write setup suw*mpy plus one cycle
// - write width ww*mpy minus 0.5
// - format bit selects separate or multiplexed
// - divide-by-2 pbus pads odd cycles even
// - divide-by-3 pbus pads to multiple three
// - divide-by-4 pbus pads to multiple four
// - ale high at start, low half before strobe; with it on a half-cycle setup
// - ale driven for internal and external spaces
module ext_bus_timing
   import ext_bus_timing_pkg::*;
(
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic [1:0] base_divider,
   input wire logic [1:0] pbus_divide,
   input wire space_timing_type [SPACE_COUNT-1:0] space_timing_config,
   input wire logic access_valid,
   input wire access_type access,
   output logic access_ready,
   output logic cycle_done,
   output logic rd_strobe_n,
   output logic wr_strobe_n,
   output logic addr_latch_enable,
   output logic [1:0] active_space
);

   // ****************************************
   // half-base-clock tick
   // ****************************************
   phase_type phase;
   logic [1:0] div_cnt;
   logic half_tick;
   logic accept;

   assign access_ready = (phase == IDLE);
   assign accept = access_valid && access_ready;
   // base clock = ref_clk / (2*(base_divider+1)); one tick per half
   assign half_tick = (div_cnt == base_divider);

   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         div_cnt <= 2'h0;
      end else if (accept || half_tick) begin
         // restart so the first half of a cycle is never short
         div_cnt <= 2'h0;
      end else begin
         div_cnt <= div_cnt + 2'h1;
      end
   end

   // ****************************************
   // phase lengths of the requested access
   // ****************************************
   space_timing_type cfg;
   logic [2:0] mpy;
   logic [4:0] setup_prod;
   logic [4:0] width_prod;
   logic [HALF_W-1:0] next_setup_len;
   logic [HALF_W-1:0] next_width_len;
   logic [HALF_W-1:0] sum_len;
   logic [CYC_W-1:0] whole_cyc;
   logic [CYC_W-1:0] padded_cyc;
   logic [HALF_W-1:0] next_tail_len;
   logic mux_fmt;

   always_comb begin
      cfg = space_timing_config[access.space];
      mux_fmt = (cfg.bus_format_select == FORMAT_MULTIPLEXED);
      mpy = {1'b0, cfg.timing_multiplier} + 3'h1;
      if (access.write) begin
         setup_prod = 5'({3'h0, cfg.write_setup_count} * {2'h0, mpy});
         width_prod = 5'(({3'h0, cfg.write_width_count} + 5'h01) * {2'h0, mpy});
         next_setup_len = 7'({setup_prod, 1'b0}) + WRITE_SETUP_ADD;
         next_width_len = 7'({width_prod, 1'b0}) - WRITE_WIDTH_SUB;
      end else begin
         setup_prod = 5'({3'h0, cfg.read_setup_count} * {2'h0, mpy});
         width_prod = 5'(({3'h0, cfg.read_width_count} + 5'h01) * {2'h0, mpy});
         next_setup_len = 7'({setup_prod, 1'b0})
            + (mux_fmt ? MUX_READ_SETUP_ADD : SEP_READ_SETUP_ADD);
         if (mux_fmt) begin
            next_width_len = 7'({width_prod, 1'b0}) - MUX_READ_WIDTH_SUB;
         end else begin
            next_width_len = 7'({width_prod, 1'b0}) + SEP_READ_WIDTH_ADD;
         end
      end
      sum_len = next_setup_len + next_width_len;
      // a trailing half cycle rounds up to a whole base cycle
      whole_cyc = 6'((sum_len + 7'h01) >> 1);
      unique case (pbus_divide)
         PBUS_DIV1: padded_cyc = whole_cyc;
         PBUS_DIV2: padded_cyc = whole_cyc + {5'h00, whole_cyc[0]};
         PBUS_DIV3: padded_cyc = whole_cyc + 6'((6'h03 - (whole_cyc % 6'h03)) % 6'h03);
         PBUS_DIV4: padded_cyc = (whole_cyc + 6'h03) & 6'h3c;
      endcase
      next_tail_len = 7'({padded_cyc, 1'b0}) - sum_len;
   end

   // ****************************************
   // phase sequencer
   // ****************************************
   logic [HALF_W-1:0] remain;
   logic [HALF_W-1:0] setup_len;
   logic [HALF_W-1:0] width_len;
   logic [HALF_W-1:0] tail_len;
   logic is_write;

   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         phase <= IDLE;
         remain <= 7'h00;
         setup_len <= 7'h00;
         width_len <= 7'h00;
         tail_len <= 7'h00;
         is_write <= 1'b0;
         active_space <= 2'h0;
      end else begin
         unique case (phase)
            IDLE: begin
               if (accept) begin
                  phase <= SETUP;
                  remain <= next_setup_len;
                  setup_len <= next_setup_len;
                  width_len <= next_width_len;
                  tail_len <= next_tail_len;
                  is_write <= access.write;
                  active_space <= access.space;
               end
            end
            SETUP: begin
               if (half_tick) begin
                  if (remain == 7'h01) begin
                     phase <= PULSE;
                     remain <= width_len;
                  end else begin
                     remain <= remain - 7'h01;
                  end
               end
            end
            PULSE: begin
               if (half_tick) begin
                  if (remain != 7'h01) begin
                     remain <= remain - 7'h01;
                  end else if (tail_len == 7'h00) begin
                     phase <= IDLE;
                  end else begin
                     phase <= PAD;
                     remain <= tail_len;
                  end
               end
            end
            PAD: begin
               if (half_tick) begin
                  if (remain == 7'h01) begin
                     phase <= IDLE;
                  end else begin
                     remain <= remain - 7'h01;
                  end
               end
            end
         endcase
      end
   end

   // ****************************************
   // pin outputs
   // ****************************************
   logic last_half;

   assign last_half = half_tick && (remain == 7'h01);

   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         rd_strobe_n <= 1'b1;
         wr_strobe_n <= 1'b1;
      end else if (phase == SETUP && last_half) begin
         rd_strobe_n <= is_write;
         wr_strobe_n <= !is_write;
      end else if (phase == PULSE && last_half) begin
         rd_strobe_n <= 1'b1;
         wr_strobe_n <= 1'b1;
      end
   end

   // internal spaces get ale too, so no space filter here
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         addr_latch_enable <= 1'b0;
      end else if (accept) begin
         addr_latch_enable <= 1'b1;
      end else if (phase == SETUP && half_tick && (remain == 7'h02 || remain == 7'h01)) begin
         // a half-cycle setup leaves no room; ale then falls with the strobe
         addr_latch_enable <= 1'b0;
      end
   end

   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         cycle_done <= 1'b0;
      end else begin
         cycle_done <= last_half && ((phase == PAD) || (phase == PULSE && tail_len == 7'h00));
      end
   end

   // ****************************************
   // checks
   // ****************************************
   logic [REF_W-1:0] low_cnt;
   logic [REF_W-1:0] run_cnt;
   logic [REF_W-1:0] half_ref;

   assign half_ref = {10'h000, base_divider} + 12'h001;

   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         low_cnt <= 12'h000;
         run_cnt <= 12'h000;
      end else begin
         low_cnt <= (rd_strobe_n && wr_strobe_n) ? 12'h000 : low_cnt + 12'h001;
         run_cnt <= accept ? 12'h001 : (phase == IDLE ? 12'h000 : run_cnt + 12'h001);
      end
   end

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (sys_rst);

   AST_ONE_STROBE: assert property (!(!rd_strobe_n && !wr_strobe_n))
      else $error("read and write strobes low together");
   AST_ALE_AT_START: assert property (accept |=> addr_latch_enable && rd_strobe_n && wr_strobe_n)
      else $error("ale not raised at bus cycle start");
   AST_ALE_INTERNAL: assert property (accept && access.internal |=> addr_latch_enable)
      else $error("ale missing on internal access");
   AST_ALE_LOW_AT_STROBE: assert property (($fell(rd_strobe_n) || $fell(wr_strobe_n)) |-> !addr_latch_enable)
      else $error("ale still high when strobe falls");
   // low_cnt already holds the full low span in the cycle the strobe is seen high again
   AST_PULSE_WIDTH: assert property ($rose(rd_strobe_n) || $rose(wr_strobe_n) |->
      low_cnt == 12'({5'h00, width_len} * half_ref))
      else $error("strobe low time differs from programmed width");
   AST_READ_SETUP_PARITY: assert property (accept && !access.write |=>
      setup_len[0] == (space_timing_config[active_space].bus_format_select == FORMAT_SEPARATE))
      else $error("read setup half offset wrong for format");
   AST_WRITE_SETUP_WHOLE: assert property (accept && access.write |=> setup_len[0] == 1'b0 && setup_len >= 7'h02)
      else $error("write setup not whole cycles plus one");
   AST_WRITE_WIDTH_HALF: assert property (accept && access.write |=> width_len[0] == 1'b1)
      else $error("write width lacks half cycle offset");
   AST_MPY_FOUR: assert property (accept && cfg.timing_multiplier == 2'h3 && !access.write
      && cfg.read_setup_count == 2'h3 && !mux_fmt |=> setup_len == 7'h19)
      else $error("multiplier 4 read setup not 12.5 cycles");
   AST_PAD_MULTIPLE: assert property (cycle_done |-> ($past(run_cnt)
      % (12'h002 * half_ref * ({10'h000, pbus_divide} + 12'h001))) == 12'h000)
      else $error("bus cycle not a whole number of pbus clocks");

   COV_SEP_READ: cover property (accept && !access.write && !mux_fmt ##[1:300] cycle_done);
   COV_WRITE: cover property (accept && access.write ##[1:300] cycle_done);
   COV_MUX_PAD3: cover property (accept && mux_fmt && pbus_divide == PBUS_DIV3 ##[1:300] phase == PAD);

endmodule

// [ext_bus_partner.sv]
`timescale 1ns/100ps
module ext_bus_partner #(
   parameter int PERIOD_NS = 25
) (
   input wire logic rd_strobe_n,
   input wire logic wr_strobe_n,
   input wire logic addr_latch_enable,
   output int setup_cyc,
   output int width_cyc,
   output int lead_cyc,
   output int latch_count,
   output int rd_count,
   output int wr_count
);
   // ****************************************
   // edge stamps of latch strobe and bus strobes
   // ****************************************
   logic strobe_n;
   // real stamps: clock edges sit on half nanoseconds
   realtime t_ale_up = 0;
   realtime t_ale_dn = 0;
   realtime t_low = 0;

   assign strobe_n = rd_strobe_n & wr_strobe_n;

   always @(posedge addr_latch_enable) t_ale_up = $realtime;

   // address is captured here, on the falling edge only
   always @(negedge addr_latch_enable) begin
      t_ale_dn = $realtime;
      latch_count = latch_count + 1;
   end

   always @(negedge rd_strobe_n) rd_count = rd_count + 1;
   always @(negedge wr_strobe_n) wr_count = wr_count + 1;
   always @(negedge strobe_n) t_low = $realtime;

   // measured at strobe rise, so a latch edge in the same step is already stamped
   always @(posedge strobe_n) begin
      setup_cyc = int'((t_low - t_ale_up) / PERIOD_NS);
      width_cyc = int'(($realtime - t_low) / PERIOD_NS);
      lead_cyc = int'((t_low - t_ale_dn) / PERIOD_NS);
   end
endmodule

// [testbench.sv]
`timescale 1ns/100ps
module testbench
   import ext_bus_timing_pkg::*;
;
   typedef struct packed {
      space_timing_type cfg;
      access_type acc;
      logic [1:0] bd;
      logic [1:0] pd;
   } case_type;

   // ****************************************
   // cases: {format, mpy, rs, rw, ws, ww}, {write, internal, space}, base div, pbus div
   // ****************************************
   // never mpy 1 with count 0 on a mux read width or a write width
   localparam int NUM = 9;
   case_type cases [NUM] = '{
      '{'{1'b0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0}, '{1'b0, 1'b0, 2'h0}, 2'h0, 2'h0},
      '{'{1'b1, 2'h1, 2'h3, 2'h1, 2'h0, 2'h0}, '{1'b0, 1'b0, 2'h1}, 2'h1, 2'h1},
      '{'{1'b0, 2'h2, 2'h0, 2'h0, 2'h2, 2'h2}, '{1'b1, 1'b0, 2'h2}, 2'h0, 2'h2},
      '{'{1'b0, 2'h3, 2'h0, 2'h0, 2'h1, 2'h0}, '{1'b1, 1'b0, 2'h3}, 2'h0, 2'h3},
      '{'{1'b0, 2'h2, 2'h1, 2'h1, 2'h0, 2'h0}, '{1'b0, 1'b1, 2'h0}, 2'h2, 2'h1},
      '{'{1'b1, 2'h0, 2'h0, 2'h0, 2'h3, 2'h1}, '{1'b1, 1'b1, 2'h1}, 2'h0, 2'h3},
      '{'{1'b1, 2'h3, 2'h0, 2'h2, 2'h0, 2'h0}, '{1'b0, 1'b0, 2'h2}, 2'h3, 2'h2},
      '{'{1'b0, 2'h0, 2'h2, 2'h3, 2'h0, 2'h0}, '{1'b0, 1'b0, 2'h3}, 2'h0, 2'h0},
      '{'{1'b0, 2'h3, 2'h3, 2'h3, 2'h0, 2'h0}, '{1'b0, 1'b1, 2'h0}, 2'h1, 2'h3}
   };

   logic ref_clk;
   logic sys_rst;
   logic [1:0] base_divider;
   logic [1:0] pbus_divide;
   space_timing_type [SPACE_COUNT-1:0] space_timing_config;
   logic access_valid;
   access_type access;
   logic access_ready;
   logic cycle_done;
   logic rd_strobe_n;
   logic wr_strobe_n;
   logic addr_latch_enable;
   logic [1:0] active_space;
   int setup_cyc;
   int width_cyc;
   int lead_cyc;
   int latch_count;
   int rd_count;
   int wr_count;
   int err_total = 0;
   int check_count = 0;

   ext_bus_timing i_dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .base_divider(base_divider),
      .pbus_divide(pbus_divide), .space_timing_config(space_timing_config), .access_valid(access_valid),
      .access(access), .access_ready(access_ready), .cycle_done(cycle_done), .rd_strobe_n(rd_strobe_n),
      .wr_strobe_n(wr_strobe_n), .addr_latch_enable(addr_latch_enable), .active_space(active_space));

   ext_bus_partner i_partner (.rd_strobe_n(rd_strobe_n), .wr_strobe_n(wr_strobe_n),
      .addr_latch_enable(addr_latch_enable), .setup_cyc(setup_cyc), .width_cyc(width_cyc),
      .lead_cyc(lead_cyc), .latch_count(latch_count), .rd_count(rd_count), .wr_count(wr_count));

   initial begin
      ref_clk = 1'b0;
      forever #12.5 ref_clk = ~ref_clk;
   end

   task automatic tally_and_finish();
      if (err_total == 0 && check_count > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
      check_count++;
      if (seen !== exp) begin
         err_total++;
         $display("mismatch at %0t: %s seen %0d expected %0d", $time, what, seen, exp);
      end
   endtask

   // ****************************************
   // one bus cycle, with a refused request poked in while busy
   // ****************************************
   task automatic run_case(input case_type tc);
      int m, h, s, w, d, p, n, lc, rc, wc;
      m = tc.cfg.timing_multiplier + 1;
      h = tc.bd + 1;
      if (tc.acc.write) begin
         s = 2 * tc.cfg.write_setup_count * m + 2;
         w = 2 * (tc.cfg.write_width_count + 1) * m - 1;
      end else begin
         s = 2 * tc.cfg.read_setup_count * m + (tc.cfg.bus_format_select ? 2 : 1);
         w = 2 * (tc.cfg.read_width_count + 1) * m + (tc.cfg.bus_format_select ? -1 : 1);
      end
      d = tc.pd + 1;
      p = ((s + w + 1) / 2 + d - 1) / d * d;
      lc = latch_count;
      rc = rd_count;
      wc = wr_count;
      @(posedge ref_clk);
      base_divider <= tc.bd;
      pbus_divide <= tc.pd;
      space_timing_config[tc.acc.space] <= tc.cfg;
      access <= tc.acc;
      access_valid <= 1'b1;
      @(posedge ref_clk);
      access_valid <= 1'b0;
      n = 0;
      do begin
         @(posedge ref_clk);
         access_valid <= (n == 1);
         n++;
         #1;
         if (n == 1) check(access_ready, 1'b0, "ready while busy");
      end while (cycle_done !== 1'b1 && n < 600);
      check(n, p * 2 * h, "cycle length");
      check(access_ready, 1'b1, "ready at done");
      check(active_space, tc.acc.space, "space");
      repeat (3) @(posedge ref_clk);
      #1;
      check(setup_cyc, s * h, "setup");
      check(width_cyc, w * h, "strobe width");
      check(lead_cyc, (s == 1) ? 0 : h, "latch lead");
      check(latch_count - lc, 1, "latch strobes");
      check(rd_count - rc, !tc.acc.write, "read strobes");
      check(wr_count - wc, tc.acc.write, "write strobes");
   endtask

   initial begin
      sys_rst = 1'b1;
      base_divider = 2'h0;
      pbus_divide = 2'h0;
      space_timing_config = '0;
      access_valid = 1'b0;
      access = ACCESS_RESET;
      repeat (10) @(posedge ref_clk);
      sys_rst <= 1'b0;
      for (int i = 0; i < NUM; i++) begin
         run_case(cases[i]);
      end
      tally_and_finish();
   end

   // longest case is under two hundred cycles; nine of them fit well inside this
   initial begin
      #100000;
      err_total++;
      tally_and_finish();
   end
endmodule
